// File: sensor_frame_dev.sv
/*
  Sensor end of the serial frame link: samples the link on clk,
  answers reads in-frame, checks and generates crc, issues writes
  and conversion starts. Assumes clk at least 8x the link clock
  and reg_rdata valid one clk after reg_addr changes.
*/
module sensor_frame_dev #(
  parameter int ERR_BITS = 4
) (
  input wire logic clk,
  input wire logic rst,
  spi_link_if.device link,
  output logic [spi_frame_pkg::ADDR_BITS-1:0] reg_addr,
  input wire logic [spi_frame_pkg::REG_BITS-1:0] reg_rdata,
  output logic wr_en,
  output logic [spi_frame_pkg::ADDR_BITS-1:0] wr_addr,
  output logic [spi_frame_pkg::REG_BITS-1:0] wr_data,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [spi_frame_pkg::FMT_BITS-1:0] data_type,
  input wire logic cfg_reset_flag,
  input wire logic alert_flag_high,
  input wire logic alert_flag_low,
  input wire logic [3:0] conversion_state_reg,
  input wire logic [ERR_BITS-1:0] error_flags,
  input wire logic [spi_frame_pkg::CH_BITS-1:0] chan_a,
  input wire logic [spi_frame_pkg::CH_BITS-1:0] chan_b,
  output logic crc_check_on,
  output logic [spi_frame_pkg::SET_CNT_BITS-1:0] set_count
);

  // ***************************************************
  // state
  // ***************************************************
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic sck_s1;
    logic sck_s2;
    logic sck_d;
    logic sdi_s1;
    logic sdi_s2;
    logic active;
    logic special;
    logic load_data;
    logic [spi_frame_pkg::CNT_BITS-1:0] cnt;
    logic [spi_frame_pkg::FRAME_BITS-1:0] rx;
    logic [spi_frame_pkg::FRAME_BITS-1:0] tx;
    logic sdo_o;
    logic sdo_oe;
    logic crc_en;
    logic prev_crc_err;
    logic stat_sel;
    logic [spi_frame_pkg::SET_CNT_BITS-1:0] set_cnt;
    logic [spi_frame_pkg::ADDR_BITS-1:0] reg_addr;
    logic wr_en;
    logic [spi_frame_pkg::ADDR_BITS-1:0] wr_addr;
    logic [spi_frame_pkg::REG_BITS-1:0] wr_data;
    logic conv_start;
  } dev_state_type;

  dev_state_type r;
  dev_state_type n;

  logic rise;
  logic fall;
  logic [spi_frame_pkg::STAT_BITS-1:0] status;
  logic [spi_frame_pkg::FRAME_BITS-1:0] first_tx;
  logic [spi_frame_pkg::FRAME_BITS-1:0] last_rx;
  logic [3:0] peek_crc;
  logic rx_err;

  // ***************************************************
  // frame contents
  // ***************************************************

  // edges of the synchronised link clock
  assign rise = r.sck_s2 & ~r.sck_d;
  assign fall = ~r.sck_s2 & r.sck_d;

  // status word; low three bits follow last frame's select
  always_comb begin
    status = '0;
    status[11] = r.prev_crc_err;
    status[10] = cfg_reset_flag;
    status[9] = alert_flag_high;
    status[8] = alert_flag_low;
    status[7:4] = conversion_state_reg;
    status[3] = |error_flags;
    if (r.stat_sel) begin
      status[2:0] = data_type;
    end else begin
      status[2:0] = r.set_cnt;
    end
  end

  // outgoing frame built at select fall, data and crc filled later
  always_comb begin
    first_tx = '0;
    if (|data_type) begin
      first_tx[spi_frame_pkg::CHA_LSB +: spi_frame_pkg::CH_BITS] = chan_a;
      first_tx[spi_frame_pkg::CHB_LSB +: spi_frame_pkg::CH_BITS] = chan_b;
      first_tx[spi_frame_pkg::STAT_LO_LSB +: 4] = status[3:0];
    end else begin
      first_tx[spi_frame_pkg::STAT_HI_LSB +: 8] = status[11:4];
      first_tx[spi_frame_pkg::STAT_LO_LSB +: 4] = status[3:0];
    end
  end

  // received frame as complete word, checked at select rise
  assign last_rx = r.rx;
  assign rx_err = r.crc_en & (spi_frame_pkg::crc4(last_rx[31:4]) != last_rx[3:0]);
  // early look at crc bits 3..1 before the last input bit
  assign peek_crc = spi_frame_pkg::crc4(r.rx[29:2]);

  // ***************************************************
  // next state
  // ***************************************************
  always_comb begin
    n = r;
    n.wr_en = 1'b0;
    n.conv_start = 1'b0;
    // two-stage synchronisers for all link inputs
    n.cs_s1 = link.cs_n;
    n.cs_s2 = r.cs_s1;
    n.sck_s1 = link.sck;
    n.sck_s2 = r.sck_s1;
    n.sck_d = r.sck_s2;
    n.sdi_s1 = link.sdi;
    n.sdi_s2 = r.sdi_s1;
    // rolling set counter, wraps by width
    if (conv_done) begin
      n.set_cnt = r.set_cnt + 3'h1;
    end
    if (r.cs_s2) begin
      // select high: link idle, output floats
      n.sdo_oe = 1'b0;
      n.active = 1'b0;
      n.load_data = 1'b0;
      if (r.active && r.cnt == spi_frame_pkg::FRAME_CNT) begin
        n.prev_crc_err = rx_err;
        if (last_rx == spi_frame_pkg::CRC_OFF_WORD) begin
          n.crc_en = 1'b0;
        end else if (!rx_err) begin
          if (last_rx[spi_frame_pkg::RW_POS] != spi_frame_pkg::READ_FLAG) begin
            n.wr_en = 1'b1;
            n.wr_addr = last_rx[spi_frame_pkg::ADDR_LSB +: spi_frame_pkg::ADDR_BITS];
            n.wr_data = last_rx[spi_frame_pkg::DATA_LSB +: spi_frame_pkg::REG_BITS];
          end
          n.conv_start = last_rx[spi_frame_pkg::conversion_start_cmd];
          n.stat_sel = last_rx[spi_frame_pkg::status_select_cmd];
        end
      end
    end else if (!r.active) begin
      // select just fell: start a frame, first bit out at once
      n.active = 1'b1;
      n.sdo_oe = 1'b1;
      n.cnt = '0;
      n.special = |data_type;
      n.tx = first_tx;
      n.sdo_o = first_tx[spi_frame_pkg::FRAME_BITS-1];
    end else begin
      // read data lands one clk after the address goes out
      if (r.load_data) begin
        n.tx[spi_frame_pkg::DATA_LSB +: spi_frame_pkg::REG_BITS] = reg_rdata;
        n.load_data = 1'b0;
      end
      if (rise && r.cnt != spi_frame_pkg::FRAME_CNT) begin
        n.rx = {r.rx[30:0], r.sdi_s2};
        n.cnt = r.cnt + 6'h01;
        // address complete: fetch read data in regular mode
        if (r.cnt == spi_frame_pkg::ADDR_DONE_CNT && !r.special &&
            r.rx[6] == spi_frame_pkg::READ_FLAG) begin
          n.reg_addr = {r.rx[5:0], r.sdi_s2};
          n.load_data = 1'b1;
        end
        // outgoing body is final: append its crc
        if (r.cnt == spi_frame_pkg::CRC_LOAD_CNT) begin
          n.tx[3:0] = spi_frame_pkg::crc4(r.tx[31:4]);
        end
        // input crc already wrong: spoil our own last bit
        if (r.cnt == spi_frame_pkg::CRC_PEEK_CNT && r.crc_en &&
            peek_crc[3:1] != {r.rx[1:0], r.sdi_s2}) begin
          n.tx[0] = ~r.tx[0];
        end
      end
      // next output bit on each falling link edge
      if (fall && r.cnt != '0 && r.cnt != spi_frame_pkg::FRAME_CNT) begin
        n.sdo_o = r.tx[5'(spi_frame_pkg::FRAME_BITS - 1 - int'(r.cnt))];
      end
    end
  end

  // ***************************************************
  // registers
  // ***************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.cs_s1 <= 1'b1;
      r.cs_s2 <= 1'b1;
      r.crc_en <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  assign link.sdo_o = r.sdo_o;
  assign link.sdo_oe = r.sdo_oe;
  assign reg_addr = r.reg_addr;
  assign wr_en = r.wr_en;
  assign wr_addr = r.wr_addr;
  assign wr_data = r.wr_data;
  assign conv_start = r.conv_start;
  assign crc_check_on = r.crc_en;
  assign set_count = r.set_cnt;
endmodule

// File: spi_frame_pkg.sv
/*
  Shared constants for the 32-bit crc-protected serial frame link:
  frame layout, crc helper, timing and the controller's apb map.
  Assumes both ends and the bench compile this package first.
*/
// Notes on behaviour
// - chip select high: ignore link, float output
// - controller holds select low whole frame
// - select rising ends frame, link disabled
// - input bits taken on rising clock only
// - start bit launches conversion at select rise
// - select bit picks counter or format status
// - set counter counts conversions, wraps at seven
// - format zero: data, twelve status, crc
// - status 10..4 copied from flag inputs
// - status 11 flags previous input crc error
// - error summary is or of errors
// - nonzero format: two 12-bit channel results
// - channel frames persist until format cleared
// - special frame: error bit plus three selected
// - low four bits carry crc both ways
// - crc over 28 bits plus zeros, preset ones
// - bad crc discards the write
// - input crc error inverts last output bit; device does so only for bad crc bits 3..1
// - crc check on at reset, command disables
// - read data returned inside same frame
// - special mode ignores address and data; the device still issues writes in special mode
// - every transfer exactly one 32-bit frame
// - output changes falling, input sampled rising
package spi_frame_pkg;

  // ***************************************************
  // frame layout
  // ***************************************************
  localparam int FRAME_BITS = 32;
  localparam int BODY_BITS = 28;
  localparam int CRC_BITS = 4;
  localparam int ADDR_BITS = 7;
  localparam int REG_BITS = 16;
  localparam int CH_BITS = 12;
  localparam int STAT_BITS = 12;
  localparam int FMT_BITS = 3;
  localparam int SET_CNT_BITS = 3;
  localparam int CNT_BITS = 6;
  localparam int RW_POS = 31;
  localparam int ADDR_LSB = 24;
  localparam int DATA_LSB = 8;
  localparam int conversion_start_cmd = 4;
  localparam int status_select_cmd = 5;
  localparam int reserved_cmd_a = 6;
  localparam int reserved_cmd_b = 7;
  localparam int STAT_LO_LSB = 4;
  localparam int STAT_HI_LSB = 24;
  localparam int CHA_LSB = 20;
  localparam int CHB_LSB = 8;
  localparam logic READ_FLAG = 1'b1;
  // rising-edge counts at which the device acts
  localparam logic [5:0] ADDR_DONE_CNT = 6'h07;
  localparam logic [5:0] CRC_LOAD_CNT = 6'h1b;
  localparam logic [5:0] CRC_PEEK_CNT = 6'h1e;
  localparam logic [5:0] FRAME_CNT = 6'h20;

  // ***************************************************
  // crc
  // ***************************************************
  localparam logic [3:0] CRC_PRESET = 4'hf;
  localparam logic [31:0] CRC_OFF_WORD = 32'h0f000407;

  // x^4+x+1, body msb first then four zeros
  function automatic logic [3:0] crc4(input logic [27:0] body);
    logic [31:0] padded;
    logic [3:0] c;
    logic inv;
    padded = {body, 4'h0};
    c = CRC_PRESET;
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      inv = padded[i] ^ c[3];
      c = {c[2], c[1], c[0] ^ inv, inv};
    end
    return c;
  endfunction

  // ***************************************************
  // timing and controller registers
  // ***************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCK_HALF_NS = 800;
  localparam int SCK_HALF_CYC = SCK_HALF_NS / CLK_PERIOD_NS;
  localparam int APB_ADDR_BITS = 8;
  localparam logic [7:0] TX_OFS = 8'h00;
  localparam logic [7:0] RX_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam int STATUS_BUSY_POS = 0;
  localparam int STATUS_CRC_OK_POS = 1;
endpackage

// File: spi_link_if.sv
/*
  Four-wire serial link between controller and sensor device.
  Resolves the device's three-state output into the sdo wire.
*/
interface spi_link_if;
  logic cs_n;
  logic sck;
  logic sdi;
  logic sdo_o;
  logic sdo_oe;
  wire sdo;

  // released line shows the inverse of the last bit, so a stray sample shows
  assign sdo = sdo_oe ? sdo_o : ~sdo_o;

  modport device (
    input cs_n,
    input sck,
    input sdi,
    output sdo_o,
    output sdo_oe
  );
  modport controller (
    output cs_n,
    output sck,
    output sdi,
    input sdo
  );
endinterface

// File: frame_ctl.sv
/*
  Controller end of the serial frame link, an apb slave: a write to
  the transmit register while idle sends one 28-bit body with its crc; the
  received word and status are read back. Makes the link clock by
  dividing clk. Assumes a single apb master on clk.
*/
module frame_ctl (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [spi_frame_pkg::APB_ADDR_BITS-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  spi_link_if.controller link
);
  parameter int HALF_CYC = spi_frame_pkg::SCK_HALF_CYC;

  typedef enum logic [2:0] {st_idle, st_setup, st_high, st_low, st_hold} ctl_state_type;

  typedef struct packed {
    ctl_state_type st;
    logic [7:0] div;
    logic [spi_frame_pkg::CNT_BITS-1:0] bits;
    logic [31:0] tx;
    logic [31:0] rx;
    logic [31:0] rx_word;
    logic sdo_s1;
    logic sdo_s2;
    logic cs_n;
    logic sck;
    logic sdi;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ctl_reg_type;

  ctl_reg_type r;
  ctl_reg_type n;
  logic half_done;
  logic access;

  assign half_done = r.div == 8'(HALF_CYC - 1);
  assign access = psel & penable & ~r.pready;

  // ***************************************************
  // apb slave and frame sequencer
  // ***************************************************
  always_comb begin
    n = r;
    n.sdo_s1 = link.sdo;
    n.sdo_s2 = r.sdo_s1;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.prdata = '0;
    n.div = half_done ? 8'h00 : r.div + 8'h01;
    // register access answers one clk into the access phase
    if (access) begin
      n.pready = 1'b1;
      case (paddr)
        spi_frame_pkg::TX_OFS: begin
          if (pwrite && r.st == st_idle) begin
            n.tx = {pwdata[27:0], spi_frame_pkg::crc4(pwdata[27:0])};
            n.st = st_setup;
            n.cs_n = 1'b0;
            n.sdi = pwdata[27];
            n.bits = '0;
            n.div = '0;
          end else if (pwrite) begin
            n.pslverr = 1'b1;
          end
        end
        spi_frame_pkg::RX_OFS: n.prdata = r.rx_word;
        spi_frame_pkg::STATUS_OFS: begin
          n.prdata[spi_frame_pkg::STATUS_BUSY_POS] = r.st != st_idle;
          n.prdata[spi_frame_pkg::STATUS_CRC_OK_POS] =
            spi_frame_pkg::crc4(r.rx_word[31:4]) == r.rx_word[3:0];
        end
        default: n.pslverr = 1'b1;
      endcase
    end
    // link clock low when idle; 32 rising edges per frame
    case (r.st)
      st_idle: n.div = '0;
      st_setup, st_low: begin
        if (half_done && r.bits == spi_frame_pkg::FRAME_CNT) begin
          n.cs_n = 1'b1;
          n.st = st_hold;
        end else if (half_done) begin
          n.sck = 1'b1;
          n.rx = {r.rx[30:0], r.sdo_s2};
          n.bits = r.bits + 6'h01;
          n.st = st_high;
        end
      end
      st_high: begin
        if (half_done) begin
          n.sck = 1'b0;
          n.tx = {r.tx[30:0], 1'b0};
          n.sdi = r.tx[30];
          n.st = st_low;
        end
      end
      st_hold: begin
        if (half_done) begin
          n.rx_word = r.rx;
          n.st = st_idle;
        end
      end
      default: n.st = st_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.st <= st_idle;
      r.cs_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign link.cs_n = r.cs_n;
  assign link.sck = r.sck;
  assign link.sdi = r.sdi;
endmodule

// File: link_chk.sv
/*
  Checker on the four link wires between controller and device.
  Assumes sck is made from clk with HALF_CYC clk per half period.
*/
module link_chk #(
  parameter int HALF_CYC = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  // ************
  // helpers
  // ************
  logic [5:0] rise_r;
  logic [7:0] high_r;

  // sck rises per frame, clk cycles of sck high
  always_ff @(posedge clk) begin
    if (rst || $fell(cs_n)) begin
      rise_r <= 6'h00;
    end else if ($rose(sck)) begin
      rise_r <= rise_r + 6'h01;
    end
    high_r <= (rst || !sck) ? 8'h00 : high_r + 8'h01;
  end

  // ************
  // assertions
  // ************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // select low, clock still, for the lead-in
  sequence lead_s;
    $fell(cs_n) ##1 !cs_n [*7];
  endsequence

  cs_lead_a: assert property (
    $fell(cs_n) |-> !sck throughout lead_s) else $error("sck moved during lead-in");
  cs_gap_a: assert property (
    $rose(cs_n) |-> cs_n [*3]) else $error("select gap too short");
  sck_idle_a: assert property (
    cs_n |-> !sck) else $error("sck active while deselected");
  out_float_a: assert property (
    cs_n [*5] |-> !sdo_oe) else $error("sdo driven while deselected");
  out_drive_a: assert property (
    $fell(cs_n) |-> ##[1:6] sdo_oe) else $error("sdo not driven in frame");
  out_edge_a: assert property (
    sdo_oe && $changed(sdo_o) |-> !sck) else $error("sdo changed while sck high");
  in_edge_a: assert property (
    !cs_n && $changed(sdi) |-> $fell(sck) || $fell(cs_n)) else $error("sdi changed off edge");
  sck_half_a: assert property (
    $fell(sck) |-> high_r == HALF_CYC) else $error("sck high time wrong");
  frame_len_a: assert property (
    $rose(cs_n) |-> rise_r == 6'h20) else $error("frame not 32 clocks");
endmodule

// File: tb_top.sv
/*
  Bench: apb-driven controller against one device end, plus a
  hand-driven link against a second device end for crc faults.
  Assumes package, interface and both ends compile first.
*/
`define CHK(a, b) begin \
  comparisons++; \
  if ((a) !== (b)) begin \
    num_errors++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); \
  end \
end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rx, q;
  logic pready, pslverr, wr_en, conv_start, crc_check_on, wr_en2, crc_on2, ok, e;
  logic [6:0] reg_addr, wr_addr;
  logic [15:0] reg_rdata, wr_data, wr_data2;
  logic conv_done = 1'b0, cfg_reset_flag = 1'b1, alert_flag_high = 1'b0;
  logic alert_flag_low = 1'b1, sel = 1'b0;
  logic [2:0] data_type = 3'h0, set_count, cnt = 3'h0;
  logic [3:0] conversion_state_reg = 4'ha, error_flags = 4'h0;
  logic [11:0] chan_a = 12'h9c3, chan_b = 12'h1e7;
  logic [27:0] b;
  int num_errors = 0, comparisons = 0, nwr = 0, nwr2 = 0, nconv = 0, w0, n0;

  spi_link_if link();
  spi_link_if l2();
  frame_ctl frame_ctl_inst (.*);
  sensor_frame_dev sensor_frame_dev_inst (.*);
  sensor_frame_dev sensor_frame_dev_inst2 (.clk(clk), .rst(rst), .link(l2),
    .reg_addr(), .reg_rdata(16'h5a5a), .wr_en(wr_en2), .wr_addr(), .wr_data(wr_data2),
    .conv_start(), .conv_done(conv_done), .data_type(3'h0), .cfg_reset_flag(cfg_reset_flag),
    .alert_flag_high(alert_flag_high), .alert_flag_low(alert_flag_low),
    .conversion_state_reg(conversion_state_reg), .error_flags(error_flags),
    .chan_a(chan_a), .chan_b(chan_b), .crc_check_on(crc_on2), .set_count());
  link_chk #(.HALF_CYC(spi_frame_pkg::SCK_HALF_CYC)) link_chk_inst (.clk(clk), .rst(rst),
    .cs_n(link.cs_n), .sck(link.sck), .sdi(link.sdi), .sdo_o(link.sdo_o),
    .sdo_oe(link.sdo_oe));

  // clock
  always #50 clk = ~clk;

  // register file answers within the clk after the address; event counters
  assign reg_rdata = {~reg_addr, 2'h2, reg_addr};
  always @(posedge clk) begin
    if (wr_en === 1'b1) nwr++;
    if (wr_en2 === 1'b1) nwr2++;
    if (conv_start === 1'b1) nconv++;
  end

  // ************
  // helpers
  // ************
  function automatic logic [3:0] crc(input logic [27:0] d);
    logic [31:0] p;
    logic [3:0] c;
    p = {d, 4'h0};
    c = 4'hf;
    for (int i = 31; i >= 0; i--) c = {c[2:0], 1'b0} ^ ((p[i] ^ c[3]) ? 4'h3 : 4'h0);
    return c;
  endfunction

  // expected device word from the status inputs
  function automatic logic [31:0] expw(input logic sp, pe, s1, input logic [15:0] d,
      input logic [2:0] n);
    logic [11:0] s;
    logic [27:0] w;
    s = {pe, cfg_reset_flag, alert_flag_high, alert_flag_low, conversion_state_reg,
      |error_flags, s1 ? data_type : n};
    w = sp ? {chan_a, chan_b, s[3:0]} : {s[11:4], d, s[3:0]};
    return {w, crc(w)};
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_idle();
    do apb(1'b0, spi_frame_pkg::STATUS_OFS, 32'h0, q, e);
    while (q[spi_frame_pkg::STATUS_BUSY_POS] !== 1'b0);
    ok = q[spi_frame_pkg::STATUS_CRC_OK_POS];
    apb(1'b0, spi_frame_pkg::RX_OFS, 32'h0, rx, e);
  endtask

  task automatic ctl_frame(input logic [27:0] d);
    apb(1'b1, spi_frame_pkg::TX_OFS, {4'h0, d}, q, e);
    wait_idle();
  endtask

  // half period of the bench-made link clock: 800 ns period at 100 ns clk
  localparam int LINK_HALF = 4;

  // hand-driven frame on the second link
  task automatic bang(input logic [31:0] w);
    l2.cs_n <= 1'b0;
    l2.sdi <= w[31];
    repeat (8) @(posedge clk);
    for (int i = 31; i >= 0; i--) begin
      l2.sck <= 1'b1;
      rx[i] = l2.sdo;
      repeat (LINK_HALF) @(posedge clk);
      l2.sck <= 1'b0;
      l2.sdi <= (i > 0) ? w[i-1] : ~w[0];
      repeat (LINK_HALF) @(posedge clk);
    end
    l2.cs_n <= 1'b1;
    repeat (16) @(posedge clk);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ************
  // tests
  // ************
  initial begin
    l2.cs_n = 1'b1;
    l2.sck = 1'b0;
    l2.sdi = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK({link.cs_n, link.sck, link.sdo_oe, set_count}, {3'h4, 3'h0});
    `CHK({crc_check_on, crc_on2}, 2'h3);
    done("reset");
    ctl_frame({1'b1, 7'h15, 20'h0});
    `CHK(rx, expw(1'b0, 1'b0, 1'b0, {~7'h15, 2'h2, 7'h15}, cnt));
    `CHK(ok, 1'b1);
    done("read");
    for (int k = 0; k < 4; k++) begin
      w0 = nwr;
      n0 = nconv;
      ctl_frame({1'b0, 7'h20 + 7'(k), 16'hbee0 + 16'(k), 2'(k), 2'(k)});
      `CHK(rx, expw(1'b0, 1'b0, sel, 16'h0, cnt));
      `CHK(nwr, w0 + 1);
      `CHK({wr_addr, wr_data}, {7'h20 + 7'(k), 16'hbee0 + 16'(k)});
      `CHK(nconv, n0 + k % 2);
      sel = k[1];
    end
    done("commands");
    repeat (9) begin
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
      repeat (3) @(posedge clk);
    end
    cnt = 3'h1;
    ctl_frame({1'b1, 7'h01, 20'h0});
    `CHK(rx, expw(1'b0, 1'b0, 1'b1, {~7'h01, 2'h2, 7'h01}, cnt));
    `CHK(set_count, 3'h1);
    done("count");
    data_type <= 3'h5;
    error_flags <= 4'h2;
    ctl_frame({1'b1, 7'h44, 16'h0, 4'h2});
    `CHK(rx, expw(1'b1, 1'b0, 1'b0, 16'h0, cnt));
    `CHK(reg_addr, 7'h01);
    ctl_frame({1'b0, 7'h45, 20'h0});
    `CHK(rx, expw(1'b1, 1'b0, 1'b1, 16'h0, cnt));
    data_type <= 3'h0;
    error_flags <= 4'h0;
    ctl_frame({1'b1, 7'h46, 20'h0});
    `CHK(rx, expw(1'b0, 1'b0, 1'b0, {~7'h46, 2'h2, 7'h46}, cnt));
    done("special");
    apb(1'b0, 8'h0c, 32'h0, q, e);
    `CHK({e, q}, {1'b1, 32'h0});
    apb(1'b1, spi_frame_pkg::TX_OFS, {5'h1, 7'h01, 20'h0}, q, e);
    apb(1'b1, spi_frame_pkg::TX_OFS, 32'h0, q, e);
    `CHK(e, 1'b1);
    wait_idle();
    `CHK(rx, expw(1'b0, 1'b0, 1'b0, {~7'h01, 2'h2, 7'h01}, cnt));
    done("refuse");
    b = {1'b0, 7'h11, 16'h1234, 4'h0};
    bang({b, crc(b) ^ 4'h8});
    `CHK(nwr2, 0);
    `CHK(rx, expw(1'b0, 1'b0, 1'b0, 16'h0, cnt) ^ 32'h1);
    bang({1'b1, 7'h11, 20'h0, crc({1'b1, 7'h11, 20'h0})});
    `CHK(rx, expw(1'b0, 1'b1, 1'b0, 16'h5a5a, cnt));
    bang(32'h0f000407);
    `CHK(crc_on2, 1'b0);
    bang({b, crc(b) ^ 4'h8});
    `CHK(nwr2, 1);
    `CHK(wr_data2, 16'h1234);
    done("crc");
    give_verdict();
  end

  // watchdog
  initial begin
    #3000000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
